// *** shared/dpr_pkg.sv ***
// shared constants, types and helpers for the dual-port cell array
package dpr_pkg;
  localparam int CELL_COUNT = 4096;
  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = CELL_COUNT / WORD_BITS;
  localparam logic [2:0] MAX_WCODE = 3'h4;

  typedef logic [11:0] dpr_addr_t;
  typedef logic [15:0] dpr_data_t;
  typedef logic [7:0] dpr_word_idx_t;
  typedef logic [3:0] dpr_bit_off_t;
  typedef logic [2:0] dpr_wcode_t;
  typedef logic [3:0] dpr_pol_t;

  // apb byte addresses
  localparam logic [31:0] CFG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  // config field positions
  localparam int CFG_WA_LSB = 0;
  localparam int CFG_WB_LSB = 4;
  localparam int CFG_DUAL_BIT = 8;
  localparam int CFG_POLA_LSB = 16;
  localparam int CFG_POLB_LSB = 20;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h00ff_0177;
  // port a 1 bit, port b 16 bits, dual, all controls active high / rising edge
  localparam logic [31:0] CFG_RESET = 32'h0000_0140;

  // bit positions inside a polarity nibble
  localparam int POL_CLK = 0;
  localparam int POL_EN = 1;
  localparam int POL_WE = 2;
  localparam int POL_RST = 3;

  // status bits
  localparam int STAT_REJECT_BIT = 0;
  localparam int STAT_COLLIDE_BIT = 1;
  localparam logic [1:0] STAT_RESET = 2'h0;

  // first cell of word a at width 2**c; upper address bits fall off the top
  function automatic dpr_addr_t cellBase(input dpr_addr_t a, input dpr_wcode_t c);
    return a << c;
  endfunction

  // low 2**c bits set
  function automatic dpr_data_t widthMask(input dpr_wcode_t c);
    logic [16:0] one;
    one = 17'h1 << (5'h1 << c);
    return dpr_data_t'(one - 17'h1);
  endfunction
endpackage

// *** hdl/dpr_port.sv ***
// one ram port: pin synchroniser, polarity, active edge detect
`timescale 1ns/1ps
module dpr_port (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEn,
  input wire dpr_pkg::dpr_pol_t pol,
  input wire logic portClk,
  input wire logic portEn,
  input wire logic portWe,
  input wire logic portRst,
  input wire dpr_pkg::dpr_addr_t portAddr,
  input wire dpr_pkg::dpr_data_t portDin,
  output logic op,
  output logic we,
  output logic rst,
  output dpr_pkg::dpr_addr_t addr,
  output dpr_pkg::dpr_data_t din
);
  import dpr_pkg::*;

  // all pins travel together so data stays aligned with its clock sample
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic clkPrev_q;
  wire logic [31:0] pinBundle = {portClk, portEn, portWe, portRst, portAddr, portDin};
  wire logic clkNow = sync2_q[31];
  wire logic risen = clkNow && !clkPrev_q;
  wire logic fallen = !clkNow && clkPrev_q;
  wire logic activeEdge = pol[POL_CLK] ? fallen : risen;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 32'h0;
      sync2_q <= 32'h0;
      clkPrev_q <= 1'b0;
    end else if (clockEn) begin
      sync1_q <= pinBundle;
      sync2_q <= sync1_q;
      clkPrev_q <= clkNow;
    end
  end

  // the enable qualifies every operation of the port
  assign op = clockEn && activeEdge && (sync2_q[30] ^ pol[POL_EN]);
  assign we = sync2_q[29] ^ pol[POL_WE];
  assign rst = sync2_q[28] ^ pol[POL_RST];
  assign addr = sync2_q[27:16];
  assign din = sync2_q[15:0];
endmodule

// *** hdl/dpr_apb.sv ***
// apb slave holding the configuration and status registers
`timescale 1ns/1ps
module dpr_apb (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic collide,
  output logic [31:0] cfg
);
  import dpr_pkg::*;

  logic [31:0] cfg_q;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  wire logic hitCfg = paddr == CFG_OFFSET;
  wire logic hitStat = paddr == STATUS_OFFSET;
  wire logic mapped = hitCfg || hitStat;
  // one wait state: answer is prepared in the first access cycle
  wire logic firstAccess = psel && penable && !pready_q;
  wire logic commit = psel && penable && pready_q;
  wire dpr_wcode_t newWa = pwdata[CFG_WA_LSB +: 3];
  wire dpr_wcode_t newWb = pwdata[CFG_WB_LSB +: 3];
  wire logic newDual = pwdata[CFG_DUAL_BIT];
  // port b never narrower than port a; single-port only checks port a
  wire logic cfgLegal = newWa <= MAX_WCODE && (!newDual || (newWb <= MAX_WCODE && newWb >= newWa));
  wire logic cfgWrite = commit && pwrite && hitCfg;
  wire logic statWrite = commit && pwrite && hitStat;
  wire logic [31:0] readMux = hitCfg ? cfg_q : (hitStat ? {30'h0, stat_q} : 32'h0);

  // write-one-to-clear, a fresh event wins over the clear
  always_comb begin
    stat_d = stat_q;
    if (statWrite) begin
      stat_d = stat_q & ~pwdata[1:0];
    end
    if (cfgWrite && !cfgLegal) begin
      stat_d[STAT_REJECT_BIT] = 1'b1;
    end
    if (collide) begin
      stat_d[STAT_COLLIDE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
      stat_q <= STAT_RESET;
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (clockEn) begin
      pready_q <= firstAccess;
      stat_q <= stat_d;
      if (firstAccess) begin
        prdata_q <= pwrite ? 32'h0 : readMux;
        pslverr_q <= !mapped;
      end
      if (cfgWrite && cfgLegal) begin
        cfg_q <= pwdata & CFG_WRITE_MASK;
      end
    end
  end

  assign cfg = cfg_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  a_pready_single: assert property (@(posedge clock) disable iff (!resetn)
    clockEn && firstAccess |=> pready ##1 (!pready || !$past(clockEn)))
    else $error("pready did not pulse one cycle after access");
  a_cfg_stays_legal: assert property (@(posedge clock) disable iff (!resetn)
    cfg_q[CFG_DUAL_BIT] |-> cfg_q[CFG_WB_LSB +: 3] >= cfg_q[CFG_WA_LSB +: 3])
    else $error("config holds port b narrower than port a");
endmodule

// *** hdl/dpr_top.sv ***
// dual-port 4096-cell ram with per-port width, polarity and output clear
`timescale 1ns/1ps
module dpr_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aClk,
  input wire logic aEn,
  input wire logic aWe,
  input wire logic aRst,
  input wire dpr_pkg::dpr_addr_t aAddr,
  input wire dpr_pkg::dpr_data_t aWriteValue,
  output dpr_pkg::dpr_data_t aDout,
  input wire logic bClk,
  input wire logic bEn,
  input wire logic bWe,
  input wire logic bRst,
  input wire dpr_pkg::dpr_addr_t bAddr,
  input wire dpr_pkg::dpr_data_t bWriteValue,
  output dpr_pkg::dpr_data_t bDout
);
  import dpr_pkg::*;

  // 4096 cells kept as 256 words of 16; a port slice never straddles a word
  dpr_data_t mem [WORD_COUNT];

  logic [31:0] cfg;
  logic opA;
  logic weA;
  logic rstA;
  dpr_addr_t addrA;
  dpr_data_t dinA;
  logic opBRaw;
  logic weB;
  logic rstB;
  dpr_addr_t addrB;
  dpr_data_t dinB;
  dpr_data_t aDout_q;
  dpr_data_t aDout_d;
  dpr_data_t bDout_q;
  dpr_data_t bDout_d;
  logic collide_q;

  wire dpr_wcode_t wA = cfg[CFG_WA_LSB +: 3];
  wire dpr_wcode_t wB = cfg[CFG_WB_LSB +: 3];
  wire logic dual = cfg[CFG_DUAL_BIT];
  // port b is dead in single-port mode
  wire logic opB = opBRaw && dual;

  dpr_apb u_apb (
    .clock(clock),
    .resetn(resetn),
    .clockEn(clockEn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .collide(collide_q),
    .cfg(cfg)
  );

  // no arbitration: each port has its own front end
  dpr_port u_port_a (
    .clock(clock),
    .resetn(resetn),
    .clockEn(clockEn),
    .pol(cfg[CFG_POLA_LSB +: 4]),
    .portClk(aClk),
    .portEn(aEn),
    .portWe(aWe),
    .portRst(aRst),
    .portAddr(aAddr),
    .portDin(aWriteValue),
    .op(opA),
    .we(weA),
    .rst(rstA),
    .addr(addrA),
    .din(dinA)
  );

  dpr_port u_port_b (
    .clock(clock),
    .resetn(resetn),
    .clockEn(clockEn),
    .pol(cfg[CFG_POLB_LSB +: 4]),
    .portClk(bClk),
    .portEn(bEn),
    .portWe(bWe),
    .portRst(bRst),
    .portAddr(bAddr),
    .portDin(bWriteValue),
    .op(opBRaw),
    .we(weB),
    .rst(rstB),
    .addr(addrB),
    .din(dinB)
  );

  // width dependent mapping onto the shared cells
  wire dpr_addr_t cellA = cellBase(addrA, wA);
  wire dpr_addr_t cellB = cellBase(addrB, wB);
  wire dpr_word_idx_t wordA = cellA[11:4];
  wire dpr_word_idx_t wordB = cellB[11:4];
  wire dpr_bit_off_t offA = cellA[3:0];
  wire dpr_bit_off_t offB = cellB[3:0];
  wire dpr_data_t mA = widthMask(wA);
  wire dpr_data_t mB = widthMask(wB);
  wire dpr_data_t dinAm = dinA & mA;
  wire dpr_data_t dinBm = dinB & mB;
  wire dpr_data_t laneA = mA << offA;
  wire dpr_data_t laneB = mB << offB;

  // clear of the output never blocks the write
  wire logic wrA = opA && weA;
  wire logic wrB = opB && weB;
  wire logic sameWord = wrA && wrB && wordA == wordB;
  wire logic overlap = sameWord && (laneA & laneB) != 16'h0;

  wire dpr_data_t newWordA = (mem[wordA] & ~laneA) | (dinAm << offA);
  // both ports hitting one word: merge, b lands last on shared cells
  wire dpr_data_t baseB = sameWord ? newWordA : mem[wordB];
  wire dpr_data_t newWordB = (baseB & ~laneB) | (dinBm << offB);

  wire dpr_data_t rdA = (mem[wordA] >> offA) & mA;
  wire dpr_data_t rdB = (mem[wordB] >> offB) & mB;

  // single-edge write; memory has no reset so it maps onto block ram
  always_ff @(posedge clock) begin
    if (clockEn) begin
      if (wrA && !sameWord) begin
        mem[wordA] <= newWordA;
      end
      if (wrB) begin
        mem[wordB] <= newWordB;
      end
    end
  end

  // output register: clear beats write mirror beats read
  always_comb begin
    aDout_d = aDout_q;
    if (opA) begin
      if (rstA) begin
        aDout_d = 16'h0;
      end else if (weA) begin
        aDout_d = dinAm;
      end else begin
        aDout_d = rdA;
      end
    end
  end

  always_comb begin
    bDout_d = bDout_q;
    if (opB) begin
      if (rstB) begin
        bDout_d = 16'h0;
      end else if (weB) begin
        bDout_d = dinBm;
      end else begin
        bDout_d = rdB;
      end
    end
  end

  // holds between enabled edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aDout_q <= 16'h0;
      bDout_q <= 16'h0;
      collide_q <= 1'b0;
    end else if (clockEn) begin
      aDout_q <= aDout_d;
      bDout_q <= bDout_d;
      collide_q <= overlap;
    end
  end

  assign aDout = aDout_q;
  assign bDout = bDout_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_writeA;
    opA && weA && !rstA;
  endsequence

  sequence s_clearA;
    opA && rstA;
  endsequence

  a_idle_holds_a: assert property ((!opA || !clockEn) |=> $stable(aDout))
    else $error("port a output moved without an enabled edge");
  a_idle_holds_b: assert property (!opB |=> $stable(bDout))
    else $error("port b output moved without an enabled edge");
  a_clear_zeroes: assert property (s_clearA |=> aDout == 16'h0)
    else $error("port a output not cleared");
  a_clear_keeps_cells: assert property (s_clearA ##0 (!weA && !wrB)
    |=> mem[$past(wordA)] == $past(mem[wordA]))
    else $error("output clear changed the array");
  a_write_mirrors: assert property (s_writeA |=> aDout == $past(dinAm))
    else $error("write data not mirrored on port a output");
  a_write_lands: assert property ((opA && weA && !wrB)
    |=> ((mem[$past(wordA)] >> $past(offA)) & $past(mA)) == $past(dinAm))
    else $error("port a write not stored in one edge");
  a_clear_b_write_a: assert property ((opB && rstB && wrA && !wrB)
    |=> ((mem[$past(wordA)] >> $past(offA)) & $past(mA)) == $past(dinAm))
    else $error("port b clear disturbed a port a write");
  a_read_returns: assert property ((opB && !weB && !rstB && !wrA)
    |=> bDout == $past(rdB))
    else $error("port b read returned the wrong cells");
  // a width change alone leaves the held output as it was, so check after operations only
  a_width_unused_zero: assert property (opA |=> (aDout & ~$past(mA)) == 16'h0)
    else $error("port a output bits above port width not zero");
  a_width_zero_b: assert property (opB |=> (bDout & ~$past(mB)) == 16'h0)
    else $error("port b output bits above port width not zero");
  a_single_b_quiet: assert property (!dual |-> !opB)
    else $error("port b active in single-port mode");
  a_single_b_holds: assert property (!dual |=> $stable(bDout))
    else $error("port b output moved in single-port mode");

  sequence s_writeB;
    opB && weB && !rstB;
  endsequence

  sequence s_clearB;
    opB && rstB;
  endsequence

  sequence s_readA;
    opA && !weA && !rstA;
  endsequence

  // counterparts on the other port: b side for clear, mirror, store and keep; a side for the read check
  a_clear_zeroes_b: assert property (s_clearB |=> bDout == 16'h0)
    else $error("port b output not cleared");
  a_write_mirrors_b: assert property (s_writeB |=> bDout == $past(dinBm))
    else $error("write data not mirrored on port b output");
  a_write_lands_b: assert property ((wrB && !wrA)
    |=> ((mem[$past(wordB)] >> $past(offB)) & $past(mB)) == $past(dinBm))
    else $error("port b write not stored in one edge");
  a_read_returns_a: assert property (s_readA |=> aDout == $past(rdA))
    else $error("port a read returned the wrong cells");
  a_clear_keeps_b: assert property (s_clearB ##0 (!weB && !wrA)
    |=> mem[$past(wordB)] == $past(mem[wordB]))
    else $error("port b output clear changed the array");

  // clear together with write: output zero, cells still take the data
  a_clear_write_a: assert property (s_clearA ##0 (weA && !wrB)
    |=> aDout == 16'h0 && ((mem[$past(wordA)] >> $past(offA)) & $past(mA)) == $past(dinAm))
    else $error("port a clear with write lost the clear or the data");
  a_clear_write_b: assert property (s_clearB ##0 (weB && !wrA)
    |=> bDout == 16'h0 && ((mem[$past(wordB)] >> $past(offB)) & $past(mB)) == $past(dinBm))
    else $error("port b clear with write lost the clear or the data");

  // edge detect must give exactly one operation per port clock edge
  a_op_single_a: assert property (opA |=> !opA)
    else $error("port a operated twice for one edge");
  a_op_single_b: assert property (opB |=> !opB)
    else $error("port b operated twice for one edge");

  a_clear_a_write_b: assert property ((opA && rstA && wrB && !wrA)
    |=> ((mem[$past(wordB)] >> $past(offB)) & $past(mB)) == $past(dinBm))
    else $error("port a clear disturbed a port b write");
endmodule

// *** sim/dpr_user.sv ***
// user logic model driving one ram port through its pins
`timescale 1ns/1ps
module dpr_user (
  input wire logic clock,
  input wire dpr_pkg::dpr_pol_t pol,
  output logic pClk,
  output logic pEn,
  output logic pWe,
  output logic pRst,
  output dpr_pkg::dpr_addr_t pAddr,
  output dpr_pkg::dpr_data_t pDin
);
  import dpr_pkg::*;
  initial begin
    pClk = 1'b0;
    pEn = 1'b0;
    pWe = 1'b0;
    pRst = 1'b0;
    pAddr = 12'h0;
    pDin = 16'h0;
  end
  // enable off in the same cycle as the clock level swap, so the swap cannot start an operation
  task automatic park(input dpr_pol_t nxt);
    @(posedge clock);
    pEn <= pol[POL_EN];
    pClk <= nxt[POL_CLK];
    repeat (4) @(posedge clock);
  endtask
  task automatic op(input logic en, input logic wr, input logic clr, input dpr_addr_t ad,
                    input dpr_data_t d);
    @(posedge clock);
    pEn <= en ^ pol[POL_EN];
    pWe <= wr ^ pol[POL_WE];
    pRst <= clr ^ pol[POL_RST];
    pAddr <= ad;
    pDin <= d;
    repeat (2) @(posedge clock);
    pClk <= ~pol[POL_CLK];
    repeat (4) @(posedge clock);
    // hold over: pins stop showing the old request
    pClk <= pol[POL_CLK];
    pEn <= pol[POL_EN];
    pWe <= ~(wr ^ pol[POL_WE]);
    pRst <= ~(clr ^ pol[POL_RST]);
    pAddr <= ~ad;
    pDin <= ~d;
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the dual-port cell array
`timescale 1ns/1ps
module tb_top;
  import dpr_pkg::*;
  logic clock, resetn, clockEn, psel, penable, pwrite, pready, pslverr, err, dual;
  logic [31:0] paddr, pwdata, prdata, rd, r;
  logic aClk, aEn, aWe, aRst, bClk, bEn, bWe, bRst;
  dpr_addr_t aAddr, bAddr;
  dpr_data_t aWriteValue, bWriteValue, aDout, bDout, expA, expB;
  dpr_pol_t polA, polB;
  dpr_wcode_t cA, cB;
  logic [4095:0] cells;
  int num_errors, n_compared, seed, na, nb;
  dpr_top dut (.clock(clock), .resetn(resetn), .clockEn(clockEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aClk(aClk), .aEn(aEn), .aWe(aWe), .aRst(aRst),
    .aAddr(aAddr), .aWriteValue(aWriteValue), .aDout(aDout), .bClk(bClk), .bEn(bEn),
    .bWe(bWe), .bRst(bRst), .bAddr(bAddr), .bWriteValue(bWriteValue), .bDout(bDout));
  dpr_user uA (.clock(clock), .pol(polA), .pClk(aClk), .pEn(aEn), .pWe(aWe), .pRst(aRst),
    .pAddr(aAddr), .pDin(aWriteValue));
  dpr_user uB (.clock(clock), .pol(polB), .pClk(bClk), .pEn(bEn), .pWe(bWe), .pRst(bRst),
    .pAddr(bAddr), .pDin(bWriteValue));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic give_verdict;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apbXfer(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int cellAt(input dpr_addr_t ad, input dpr_wcode_t c);
    return int'(dpr_addr_t'(ad << c));
  endfunction
  function automatic dpr_data_t expRd(input dpr_addr_t ad, input dpr_wcode_t c);
    dpr_data_t v;
    v = 16'h0;
    for (int i = 0; i < (1 << c); i++) v[i] = cells[cellAt(ad, c) + i];
    return v;
  endfunction
  task automatic modelWr(input dpr_addr_t ad, input dpr_wcode_t c, input dpr_data_t d);
    for (int i = 0; i < (1 << c); i++) cells[cellAt(ad, c) + i] = d[i];
  endtask
  task automatic doOp(input logic pb, input logic en, input logic wr, input logic clr,
                      input dpr_addr_t ad, input dpr_data_t d);
    dpr_wcode_t c;
    dpr_data_t e;
    c = pb ? cB : cA;
    e = pb ? expB : expA;
    // port b is dead while single-port
    if (en && (!pb || dual)) begin
      e = clr ? 16'h0 : wr ? d & 16'((17'h1 << (1 << c)) - 17'h1) : expRd(ad, c);
      if (wr) modelWr(ad, c, d);
    end
    if (pb) uB.op(en, wr, clr, ad, d);
    else uA.op(en, wr, clr, ad, d);
    if (pb) expB = e;
    else expA = e;
    chk({aDout, bDout}, {expA, expB});
  endtask
  task automatic setCfg(input int a, input int b, input logic nd, input dpr_pol_t pa,
                        input dpr_pol_t pq);
    logic [31:0] w;
    w = {8'h0, pq, pa, 7'h0, nd, 1'b0, 3'(b), 1'b0, 3'(a)};
    fork
      uA.park(pa);
      uB.park(pq);
    join
    apbXfer(1'b1, CFG_OFFSET, w);
    apbXfer(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, w);
    polA = pa;
    polB = pq;
    cA = 3'(a);
    cB = 3'(b);
    dual = nd;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    $display("BAD t=%0t timeout", $time);
    num_errors++;
    give_verdict();
  end
  initial begin
    seed = 32'h10ac9fa9;
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clockEn = 1'b1;
    {polA, polB, cA, expA, expB, num_errors, n_compared} = '0;
    cB = 3'h4;
    dual = 1'b1;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chk({aDout, bDout}, 32'h0);
    apbXfer(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, CFG_RESET);
    apbXfer(1'b1, 32'h0000_0008, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    apbXfer(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0);
    // too wide a code, then port b narrower than port a
    apbXfer(1'b1, CFG_OFFSET, 32'h0000_0105);
    apbXfer(1'b1, CFG_OFFSET, 32'h0000_0124);
    apbXfer(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, CFG_RESET);
    apbXfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h1);
    apbXfer(1'b1, STATUS_OFFSET, 32'h1);
    apbXfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 256; i++) doOp(1'b1, 1'b1, 1'b1, 1'b0, 12'(i), 16'($random(seed)));
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      na = k % 5;
      nb = na + int'(r[10:8]) % (5 - na);
      setCfg(na, nb, 1'b1, r[3:0], r[7:4]);
      for (int j = 0; j < 16; j++) begin
        r = $random(seed);
        doOp(r[0], r[3:1] != 3'h0, r[4], r[7:5] == 3'h0, r[19:8], r[31:16]);
      end
    end
    setCfg(2, 0, 1'b0, 4'h0, 4'h0);
    doOp(1'b1, 1'b1, 1'b1, 1'b0, 12'h00a, 16'hffff);
    doOp(1'b0, 1'b1, 1'b0, 1'b0, 12'h00a, 16'h0);
    setCfg(0, 4, 1'b1, 4'h0, 4'h0);
    // clear on a while b writes, cells kept apart
    fork
      uA.op(1'b1, 1'b0, 1'b1, 12'h005, 16'h0);
      uB.op(1'b1, 1'b1, 1'b0, 12'h0a0, 16'h5a3c);
    join
    modelWr(12'h0a0, 3'h4, 16'h5a3c);
    expA = 16'h0;
    expB = 16'h5a3c;
    chk({aDout, bDout}, {expA, expB});
    doOp(1'b0, 1'b1, 1'b0, 1'b0, 12'ha03, 16'h0);
    // both ports write cell 0 at once: status flags it, b's data is kept
    fork
      uA.op(1'b1, 1'b1, 1'b0, 12'h000, 16'h0001);
      uB.op(1'b1, 1'b1, 1'b0, 12'h000, 16'h8000);
    join
    modelWr(12'h000, 3'h4, 16'h8000);
    expA = 16'h0001;
    expB = 16'h8000;
    chk({aDout, bDout}, {expA, expB});
    apbXfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h2);
    apbXfer(1'b1, STATUS_OFFSET, 32'h2);
    apbXfer(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    // frozen clock enable: a whole port request passes unseen
    clockEn <= 1'b0;
    uA.op(1'b1, 1'b1, 1'b0, 12'h001, 16'h0001);
    clockEn <= 1'b1;
    chk({aDout, bDout}, {expA, expB});
    doOp(1'b0, 1'b1, 1'b0, 1'b0, 12'h001, 16'h0);
    give_verdict();
  end
endmodule
